// ---- hdl/cetc_consts.svh ----
`ifndef CETC_CONSTS_SVH
`define CETC_CONSTS_SVH

// clock and timing step
`define CETC_CLK_NS          5
`define CETC_STEP_NS         15
`define CETC_STEP_CYC        (`CETC_STEP_NS / `CETC_CLK_NS)
// fixed start delay for a trigger outside readout, in 15 ns steps
`define CETC_START_DLY_STEPS 4
// over-temperature lamp half period
`define CETC_BLINK_NS        250000000
`define CETC_BLINK_CYC       (`CETC_BLINK_NS / `CETC_CLK_NS)

// register byte offsets
`define CETC_OFS_CTRL        8'h00
`define CETC_OFS_EXPO        8'h04
`define CETC_OFS_PERIOD      8'h08
`define CETC_OFS_SWTRIG      8'h0c
`define CETC_OFS_REGION      8'h10
`define CETC_OFS_MAPWR       8'h14
`define CETC_OFS_STATUS      8'h18
`define CETC_OFS_TEMPLIM     8'h1c
`define CETC_OFS_DROPS       8'h20

// control fields
`define CETC_CTRL_MODE_LSB   0
`define CETC_CTRL_MAP_EN     2
`define CETC_CTRL_FLIP_H     3
`define CETC_CTRL_FLIP_V     4
`define CETC_CTRL_BIN        5
`define CETC_CTRL_QUAL       6
`define CETC_CTRL_RATE_LIM   7
`define CETC_CTRL_REGION_EN  8

// mode codes
`define CETC_MODE_FREE       2'h0
`define CETC_MODE_PULSE      2'h1
`define CETC_MODE_PROG       2'h2

// map write fields
`define CETC_MAPWR_ADR_LSB   12

// reset values
`define CETC_CTRL_RST        32'h0000_0000
`define CETC_EXPO_RST        32'h0000_0fa0
`define CETC_PERIOD_RST      32'h0001_0000
`define CETC_REGION_RST      32'hffff_0000
`define CETC_TEMPLIM_RST     12'h800

`endif

// ---- hdl/cetc_pkg.sv ----
package cetc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ALIGN,
    ST_DELAY,
    ST_EXPOSE
  } cetc_state_t;

endpackage

// ---- hdl/cetc_top.sv ----
// Contract
// - free-run: continuous readout with line/frame valid
// - free-run: no trigger, programmed exposure length
// - pulse mode: rise starts, fall ends, readout
// - trigger during frame waits line valid fall
// - trigger outside frame: fixed short delay
// - programmed mode: rise starts, timed end
// - exposure range up to sixty seconds
// - exposure change never distorts a frame
// - software trigger replaces hardware trigger
// - timing counted in 15 ns steps
// - burst: buffer frames, deliver in order
// - full buffer drops new frames
// - trigger rate limited to free-run rate
// - map table narrows 12 to 8 bits
// - mirror horizontally or vertically in memory
// - region window selects lines, not columns
// - binned with qualifier: every third pixel
// - over-temperature flashes red lamp
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cetc_consts.svh"

module cetc_top #(
  parameter int W         = 16,
  parameter int H         = 8,
  parameter int FRAMES    = 4,
  parameter int BLINK_CYC = `CETC_BLINK_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // trigger pin and temperature monitor
  input  wire logic        trig_i,
  input  wire logic [11:0] temp_i,
  output logic             led_red_o,
  // sensor control and readout
  output logic             expose_o,
  output logic             readout_start_o,
  input  wire logic        line_valid_i,
  input  wire logic        frame_valid_i,
  input  wire logic [11:0] pixel_i,
  // output stream
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic [11:0]      out_data_o,
  output logic             out_sof_o,
  output logic             out_eol_o,
  output logic             out_eof_o
);

  localparam int CW = $clog2(W) + 1;
  localparam int RW = $clog2(H) + 1;
  localparam int PW = (FRAMES > 1) ? $clog2(FRAMES) : 1;
  localparam int NW = $clog2(FRAMES) + 1;
  localparam int AW = $clog2(FRAMES * W * H);
  localparam logic [1:0] STEP_LAST = 2'(`CETC_STEP_CYC - 1);
  localparam logic [7:0] DLY_LAST  = 8'(`CETC_START_DLY_STEPS - 1);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction

  function automatic logic [AW-1:0] addr(input logic [PW-1:0] slot, input logic [RW-1:0] row,
                                         input logic [CW-1:0] col);
    return AW'((int'(slot) * H + int'(row)) * W + int'(col));
  endfunction

  // registers
  logic [31:0] ctrl;
  logic [31:0] expo;
  logic [31:0] period;
  logic [31:0] region;
  logic [11:0] temp_lim;
  logic        sw_trig;
  logic [15:0] drops;
  logic [NW-1:0] count;
  logic        over_temp;
  logic [1:0]  fv_sy;
  wire logic   frame_valid_i_s = fv_sy[1];

  logic [7:0]  sample_map_table [0:4095];
  logic [11:0] mem [0:FRAMES*W*H-1];
  logic [RW-1:0] rows_q [0:FRAMES-1];
  logic [CW-1:0] cols_q [0:FRAMES-1];

  wire logic [1:0] mode   = ctrl[`CETC_CTRL_MODE_LSB +: 2];
  wire logic       acc    = wb_cyc_i & wb_stb_i;
  wire logic       wr_now = acc & wb_ack_o & wb_we_i;
  wire logic       full   = (count == NW'(FRAMES));

  // wishbone: ack one cycle after the request, writes land at the ack edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc & ~wb_ack_o;
      if (acc & ~wb_ack_o)
      begin
        unique case (wb_adr_i)
          `CETC_OFS_CTRL:    wb_dat_o <= ctrl;
          `CETC_OFS_EXPO:    wb_dat_o <= expo;
          `CETC_OFS_PERIOD:  wb_dat_o <= period;
          `CETC_OFS_REGION:  wb_dat_o <= region;
          `CETC_OFS_STATUS:  wb_dat_o <= {16'h0000, 8'(count), 4'h0, full, over_temp,
                                         frame_valid_i_s, expose_o};
          `CETC_OFS_TEMPLIM: wb_dat_o <= {20'h00000, temp_lim};
          `CETC_OFS_DROPS:   wb_dat_o <= {16'h0000, drops};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl     <= `CETC_CTRL_RST;
      expo     <= `CETC_EXPO_RST;
      period   <= `CETC_PERIOD_RST;
      region   <= `CETC_REGION_RST;
      temp_lim <= `CETC_TEMPLIM_RST;
      sw_trig  <= 1'b0;
    end
    else
    begin
      sw_trig <= wr_now && wb_adr_i == `CETC_OFS_SWTRIG && wb_sel_i[0] && wb_dat_i[0];
      if (wr_now)
      begin
        unique case (wb_adr_i)
          `CETC_OFS_CTRL:    ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
          `CETC_OFS_EXPO:    expo <= merge(expo, wb_dat_i, wb_sel_i);
          `CETC_OFS_PERIOD:  period <= merge(period, wb_dat_i, wb_sel_i);
          `CETC_OFS_REGION:  region <= merge(region, wb_dat_i, wb_sel_i);
          `CETC_OFS_TEMPLIM: temp_lim <= 12'(merge({20'h00000, temp_lim}, wb_dat_i, wb_sel_i));
          default:           ;
        endcase
      end
    end
  end

  // table loads take the value and index from one word
  always_ff @(posedge clk_i)
  begin
    if (wr_now && wb_adr_i == `CETC_OFS_MAPWR && wb_sel_i == 4'hf)
      sample_map_table[wb_dat_i[`CETC_CTRL_MODE_LSB + `CETC_MAPWR_ADR_LSB +: 12]] <= wb_dat_i[7:0];
  end

  // pin synchronisers
  logic [1:0]  trig_sy;
  logic [1:0]  lv_sy;
  logic [11:0] pix_s1;
  logic [11:0] pix_s;
  logic [11:0] temp_s1;
  logic [11:0] temp_s;
  logic        trig_d;
  logic        lv_d;
  logic        fv_d;
  wire logic   trig_s          = trig_sy[1];
  wire logic   line_valid_s    = lv_sy[1];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_sy <= 2'h0;
      lv_sy   <= 2'h0;
      fv_sy   <= 2'h0;
      pix_s1  <= 12'h000;
      pix_s   <= 12'h000;
      temp_s1 <= 12'h000;
      temp_s  <= 12'h000;
      trig_d  <= 1'b0;
      lv_d    <= 1'b0;
      fv_d    <= 1'b0;
    end
    else
    begin
      trig_sy <= {trig_sy[0], trig_i};
      lv_sy   <= {lv_sy[0], line_valid_i};
      fv_sy   <= {fv_sy[0], frame_valid_i};
      pix_s1  <= pixel_i;
      pix_s   <= pix_s1;
      temp_s1 <= temp_i;
      temp_s  <= temp_s1;
      trig_d  <= trig_s;
      lv_d    <= line_valid_s;
      fv_d    <= frame_valid_i_s;
    end
  end

  wire logic trig_rise = trig_s & ~trig_d;
  wire logic lv_fall   = lv_d & ~line_valid_s;
  wire logic fv_rise   = frame_valid_i_s & ~fv_d;
  wire logic fv_fall   = fv_d & ~frame_valid_i_s;

  // 15 ns step enable
  logic [1:0] step_cnt;
  wire logic  step = (step_cnt == STEP_LAST);

  // exposure control
  cetc_pkg::cetc_state_t state;
  logic [31:0] exp_len;
  logic [31:0] exp_cnt;
  logic [7:0]  dly_cnt;
  logic [31:0] gap_cnt;
  logic        pw_end;
  wire logic   any_trig = (trig_rise | sw_trig) && mode != `CETC_MODE_FREE;
  wire logic   take_trig = any_trig && gap_cnt == 32'h0 && state == cetc_pkg::ST_IDLE;
  wire logic   enter_exp = (state == cetc_pkg::ST_IDLE && mode == `CETC_MODE_FREE) ||
                           (state == cetc_pkg::ST_ALIGN && lv_fall) ||
                           (state == cetc_pkg::ST_DELAY && step && dly_cnt == DLY_LAST);

  // phase restarts at a taken trigger and at exposure start, so both spans are whole steps
  always_ff @(posedge clk_i)
  begin
    if (rst_i || step || take_trig || enter_exp)
      step_cnt <= 2'h0;
    else
      step_cnt <= step_cnt + 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gap_cnt <= 32'h0;
    else if (take_trig && ctrl[`CETC_CTRL_RATE_LIM])
      gap_cnt <= period;
    else if (step && gap_cnt != 32'h0)
      gap_cnt <= gap_cnt - 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state           <= cetc_pkg::ST_IDLE;
      exp_len         <= 32'h0;
      exp_cnt         <= 32'h0;
      dly_cnt         <= 8'h00;
      pw_end          <= 1'b0;
      expose_o        <= 1'b0;
      readout_start_o <= 1'b0;
    end
    else
    begin
      readout_start_o <= 1'b0;
      unique case (state)
        cetc_pkg::ST_IDLE:
        begin
          exp_len <= expo;
          exp_cnt <= 32'h0;
          dly_cnt <= 8'h00;
          if (mode == `CETC_MODE_FREE)
          begin
            pw_end   <= 1'b0;
            state    <= cetc_pkg::ST_EXPOSE;
            expose_o <= 1'b1;
          end
          else if (take_trig)
          begin
            pw_end <= mode == `CETC_MODE_PULSE && !sw_trig;
            if (frame_valid_i_s)
              state <= cetc_pkg::ST_ALIGN;
            else
              state <= cetc_pkg::ST_DELAY;
          end
        end
        cetc_pkg::ST_ALIGN:
        begin
          if (lv_fall)
          begin
            state    <= cetc_pkg::ST_EXPOSE;
            expose_o <= 1'b1;
          end
        end
        cetc_pkg::ST_DELAY:
        begin
          if (step)
          begin
            dly_cnt <= dly_cnt + 8'h01;
            if (dly_cnt == DLY_LAST)
            begin
              state    <= cetc_pkg::ST_EXPOSE;
              expose_o <= 1'b1;
            end
          end
        end
        cetc_pkg::ST_EXPOSE:
        begin
          if (step)
            exp_cnt <= exp_cnt + 32'h1;
          if (pw_end ? !trig_s : (step && exp_cnt + 32'h1 >= exp_len))
          begin
            state           <= cetc_pkg::ST_IDLE;
            expose_o        <= 1'b0;
            readout_start_o <= 1'b1;
          end
        end
      endcase
    end
  end

  // capture into frame memory
  logic          capturing;
  logic [15:0]   sline;
  logic [RW-1:0] row;
  logic [CW-1:0] col;
  logic [CW-1:0] colmax;
  logic [1:0]    phase;
  logic [PW-1:0] wr_slot;
  logic          push;
  wire logic line_ok = !ctrl[`CETC_CTRL_REGION_EN] ||
                       (sline >= region[15:0] && sline <= region[31:16]);
  wire logic take_px = !(ctrl[`CETC_CTRL_BIN] && ctrl[`CETC_CTRL_QUAL]) || phase == 2'h0;
  wire logic [11:0] px_val = ctrl[`CETC_CTRL_MAP_EN] ? {4'h0, sample_map_table[pix_s]} : pix_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      capturing <= 1'b0;
      sline     <= 16'h0000;
      row       <= '0;
      col       <= '0;
      colmax    <= '0;
      phase     <= 2'h0;
      wr_slot   <= '0;
      push      <= 1'b0;
      drops     <= 16'h0000;
    end
    else
    begin
      push <= 1'b0;
      if (fv_rise)
      begin
        capturing <= !full;
        if (full)
          drops <= drops + 16'h0001;
        sline  <= 16'h0000;
        row    <= '0;
        col    <= '0;
        colmax <= '0;
        phase  <= 2'h0;
      end
      else if (fv_fall)
      begin
        capturing <= 1'b0;
        if (capturing && row != '0)
        begin
          rows_q[wr_slot] <= row;
          cols_q[wr_slot] <= colmax;
          wr_slot         <= PW'(wr_slot + 1'b1);
          push            <= 1'b1;
        end
      end
      else if (lv_fall)
      begin
        sline <= sline + 16'h0001;
        col   <= '0;
        phase <= 2'h0;
        if (col != '0)
        begin
          row <= row + RW'(1);
          if (col > colmax)
            colmax <= col;
        end
      end
      else if (capturing && line_valid_s && line_ok && row < RW'(H))
      begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        if (take_px && col < CW'(W))
        begin
          mem[addr(wr_slot, row, col)] <= px_val;
          col                          <= col + CW'(1);
        end
      end
    end
  end

  // delivery at the output rate
  logic          rd_busy;
  logic [PW-1:0] rd_slot;
  logic [RW-1:0] orow;
  logic [CW-1:0] ocol;
  logic [RW-1:0] rrows;
  logic [CW-1:0] rcols;
  logic          pop;
  wire logic     adv = !out_valid_o || out_ready_i;
  wire logic     last_col = ocol == rcols - CW'(1);
  wire logic     last_row = orow == rrows - RW'(1);
  wire logic [RW-1:0] mrow = ctrl[`CETC_CTRL_FLIP_V] ? rrows - RW'(1) - orow : orow;
  wire logic [CW-1:0] mcol = ctrl[`CETC_CTRL_FLIP_H] ? rcols - CW'(1) - ocol : ocol;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_busy     <= 1'b0;
      rd_slot     <= '0;
      orow        <= '0;
      ocol        <= '0;
      rrows       <= '0;
      rcols       <= '0;
      pop         <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o  <= 12'h000;
      out_sof_o   <= 1'b0;
      out_eol_o   <= 1'b0;
      out_eof_o   <= 1'b0;
    end
    else
    begin
      pop <= 1'b0;
      if (adv)
        out_valid_o <= 1'b0;
      if (!rd_busy && !pop && count != '0)
      begin
        rd_busy <= 1'b1;
        orow    <= '0;
        ocol    <= '0;
        rrows   <= rows_q[rd_slot];
        rcols   <= cols_q[rd_slot];
      end
      else if (rd_busy && adv)
      begin
        out_valid_o <= 1'b1;
        out_data_o  <= mem[addr(rd_slot, mrow, mcol)];
        out_sof_o   <= orow == '0 && ocol == '0;
        out_eol_o   <= last_col;
        out_eof_o   <= last_col && last_row;
        ocol        <= last_col ? '0 : ocol + CW'(1);
        if (last_col)
          orow <= orow + RW'(1);
        if (last_col && last_row)
        begin
          rd_busy <= 1'b0;
          rd_slot <= PW'(rd_slot + 1'b1);
          pop     <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= '0;
    else
      count <= count + NW'(push) - NW'(pop);
  end

  // temperature watch and lamp
  logic [31:0] blink_cnt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      over_temp <= 1'b0;
      blink_cnt <= 32'h0;
      led_red_o <= 1'b0;
    end
    else
    begin
      over_temp <= temp_s > temp_lim;
      if (!over_temp)
      begin
        blink_cnt <= 32'h0;
        led_red_o <= 1'b0;
      end
      else if (blink_cnt == 32'(BLINK_CYC - 1))
      begin
        blink_cnt <= 32'h0;
        led_red_o <= ~led_red_o;
      end
      else
        blink_cnt <= blink_cnt + 32'h1;
    end
  end

endmodule

`default_nettype wire

// ---- sim/cetc_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module cetc_top_properties (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // exposure and stream
  input wire logic        expose_o,
  input wire logic        readout_start_o,
  input wire logic        out_valid_o,
  input wire logic        out_ready_i,
  input wire logic [11:0] out_data_o,
  input wire logic        out_sof_o,
  input wire logic        out_eol_o,
  input wire logic        out_eof_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rd_pulse;
    readout_start_o |=> !readout_start_o;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("readout pulse long");
  property p_rd_end;
    readout_start_o |-> !expose_o && $past(expose_o);
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("readout not at exposure end");
  property p_end_rd;
    $fell(expose_o) |-> readout_start_o;
  endproperty
  a_end_rd: assert property (p_end_rd) else $error("exposure end without readout");
  property p_hold;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
      && $stable({out_sof_o, out_eol_o, out_eof_o});
  endproperty
  a_hold: assert property (p_hold) else $error("stream beat changed");
  property p_eof_eol;
    out_valid_o && out_eof_o |-> out_eol_o;
  endproperty
  a_eof_eol: assert property (p_eof_eol) else $error("frame end not line end");
endmodule
bind cetc_top cetc_top_properties cetc_top_properties_i (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .expose_o, .readout_start_o, .out_valid_o, .out_ready_i,
  .out_data_o, .out_sof_o, .out_eol_o, .out_eof_o);
`default_nettype wire

// ---- sim/cetc_sensor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cetc_sensor_model #(
  parameter int ROWS = 8,
  parameter int COLS = 16
) (
  // control from the block
  input  wire logic        clk_i,
  input  wire logic        start_i,
  // readout framing and samples
  output logic             line_valid_o,
  output logic             frame_valid_o,
  output logic [11:0]      pixel_o
);
  initial
  begin
    line_valid_o = 1'b0;
    frame_valid_o = 1'b0;
    pixel_o = 12'h000;
  end
  // whole lines, gaps with line_valid low, samples scrambled between lines
  task automatic send_frame();
    frame_valid_o <= 1'b1;
    for (int r = 0; r < ROWS; r++)
    begin
      repeat (2) @(posedge clk_i) pixel_o <= ~pixel_o;
      for (int c = 0; c < COLS; c++)
      begin
        @(posedge clk_i);
        line_valid_o <= 1'b1;
        pixel_o <= 12'(r * 16 + c);
      end
      @(posedge clk_i);
      line_valid_o <= 1'b0;
      pixel_o <= ~pixel_o;
    end
    @(posedge clk_i);
    frame_valid_o <= 1'b0;
  endtask
  always @(posedge clk_i)
    if (start_i === 1'b1)
      send_frame();
    else
      pixel_o <= ~pixel_o;
endmodule
`default_nettype wire

// ---- sim/cetc_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cetc_consts.svh"
module cetc_top_tb_top;
  logic        clk_i, rst_i, cyc, stb, we, trig, rdy, stall;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, dat, rdat;
  logic [11:0] temp, px, od, first, second;
  logic        ack, led, expo, rds, lv, fv, ov, sof, eol, eof, lv_q, trig_q, expo_q, led_q;
  int          miscompares = 0, n_compared = 0, xcnt = 0, xlen = 0, n_rd = 0, nfr = 0;
  int          lv_age = 0, trig_age = 0, rise_d = 0, rise_age = 0, beats = 0, fbeats = 0;
  int          ntog = 0, n0, d0, nl = 0, fl = 0;
  localparam logic [31:0] TC [5] = '{32'h0a, 32'h12, 32'h102, 32'h62, 32'h06};
  localparam int          TN [5] = '{128, 128, 32, 48, 128};
  localparam logic [11:0] TF [5] = '{12'h00f, 12'h070, 12'h020, 12'h000, 12'h05a};
  localparam logic [11:0] TS [5] = '{12'h00e, 12'h071, 12'h021, 12'h003, 12'h05b};
  localparam int          TR [5] = '{8, 8, 2, 8, 8};
  cetc_top #(.BLINK_CYC(4)) cetc_top_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat),
    .wb_ack_o(ack), .trig_i(trig), .temp_i(temp), .led_red_o(led), .expose_o(expo),
    .readout_start_o(rds), .line_valid_i(lv), .frame_valid_i(fv), .pixel_i(px),
    .out_valid_o(ov), .out_ready_i(rdy), .out_data_o(od), .out_sof_o(sof),
    .out_eol_o(eol), .out_eof_o(eof));
  cetc_sensor_model cetc_sensor_model_i (.clk_i, .start_i(rds), .line_valid_o(lv),
    .frame_valid_o(fv), .pixel_o(px));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    rdy <= !stall && rdy !== 1'b1;
    lv_q <= lv;
    trig_q <= trig;
    expo_q <= expo;
    led_q <= led;
    lv_age <= (lv_q && !lv) ? 1 : lv_age + 1;
    trig_age <= (!trig_q && trig) ? 1 : trig_age + 1;
    if (led !== led_q) ntog <= ntog + 1;
    if (expo === 1'b1 && expo_q === 1'b0)
    begin
      rise_d <= trig_age;
      rise_age <= lv_age;
    end
    xcnt <= (expo === 1'b1) ? xcnt + 1 : 0;
    if (rds === 1'b1)
    begin
      xlen <= xcnt;
      n_rd <= n_rd + 1;
    end
    if (ov === 1'b1 && rdy)
    begin
      beats <= (sof === 1'b1) ? 1 : beats + 1;
      if (sof === 1'b1) first <= od;
      if (sof === 1'b0 && beats == 1) second <= od;
      if (eof === 1'b1) fbeats <= (sof === 1'b1) ? 1 : beats + 1;
      nl <= ((sof === 1'b1) ? 0 : nl) + int'(eol === 1'b1);
      if (eof === 1'b1) fl <= ((sof === 1'b1) ? 0 : nl) + int'(eol === 1'b1);
      if (eof === 1'b1) nfr <= nfr + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi)
    begin
      miscompares++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("bus answer", 1, 0);
    rdat = dat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wait_rd(input int lim);
    int m;
    m = n_rd;
    repeat (lim) if (n_rd == m) @(posedge clk_i);
  endtask
  task automatic shot(input int w);
    int m;
    m = n_rd;
    @(posedge clk_i);
    trig <= 1'b1;
    repeat (w) @(posedge clk_i);
    trig <= 1'b0;
    repeat (300) if (n_rd == m) @(posedge clk_i);
  endtask
  task automatic frame(input int nb, input int nr,
                       input logic [11:0] f0, input logic [11:0] f1);
    int m;
    m = nfr;
    repeat (3000) if (nfr == m) @(posedge clk_i);
    chk("frame beats", nb, nb == fbeats ? nb : fbeats);
    chk("frame lines", nr, fl);
    chk("first pixel", {20'h0, f0}, {20'h0, first});
    chk("second pixel", {20'h0, f1}, {20'h0, second});
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    miscompares++;
    complete_run();
  end
  initial
  begin
    {cyc, stb, we, trig, stall, adr, sel, wdat} = '0;
    temp = 12'h100;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `CETC_OFS_TEMPLIM, 0);
    chk("templim reset", 32'h800, {20'h0, rdat[11:0]});
    wb(1'b0, `CETC_OFS_PERIOD, 0);
    chk("period reset", `CETC_PERIOD_RST, rdat);
    wb(1'b0, 8'h24, 0);
    chk("unmapped read", 0, rdat);
    wb(1'b1, `CETC_OFS_EXPO, 2);
    wb(1'b0, `CETC_OFS_EXPO, 0);
    chk("expo readback", 2, rdat);
    wait_rd(13000);
    chk("free exposure", 12000, xlen);
    wait_rd(300);
    chk("changed exposure", 6, xlen);
    frame(128, 8, 12'h000, 12'h001);
    wb(1'b1, `CETC_OFS_CTRL, {30'h0, `CETC_MODE_PROG});
    repeat (2500) @(posedge clk_i);
    $display("test free run done");
    shot(60);
    chk_rng("start delay", 14, 19, rise_d);
    chk("timed exposure", 6, xlen);
    repeat (300) if (!(fv && lv)) @(posedge clk_i);
    repeat (10) @(posedge clk_i);
    shot(4);
    chk_rng("line aligned start", 2, 6, rise_age);
    repeat (1500) @(posedge clk_i);
    $display("test triggered start done");
    wb(1'b1, `CETC_OFS_CTRL, {30'h0, `CETC_MODE_PULSE});
    shot(40);
    chk_rng("pulse exposure", 22, 32, xlen);
    repeat (300) @(posedge clk_i);
    wb(1'b1, `CETC_OFS_SWTRIG, 1);
    wait_rd(300);
    chk("software exposure", 6, xlen);
    repeat (1500) @(posedge clk_i);
    $display("test pulse and software done");
    for (int i = 0; i < 128; i++)
      wb(1'b1, `CETC_OFS_MAPWR, (i << `CETC_MAPWR_ADR_LSB) | (i ^ 8'h5a));
    wb(1'b1, `CETC_OFS_REGION, {16'h3, 16'h2});
    for (int k = 0; k < 5; k++)
    begin
      wb(1'b1, `CETC_OFS_CTRL, TC[k]);
      shot(4);
      frame(TN[k], TR[k], TF[k], TS[k]);
    end
    $display("test image paths done");
    stall <= 1'b1;
    wb(1'b1, `CETC_OFS_CTRL, {30'h0, `CETC_MODE_PROG});
    wb(1'b0, `CETC_OFS_DROPS, 0);
    d0 = int'(rdat[15:0]);
    repeat (5)
    begin
      shot(4);
      repeat (200) @(posedge clk_i);
    end
    wb(1'b0, `CETC_OFS_DROPS, 0);
    chk("dropped frames", d0 + 1, {16'h0, rdat[15:0]});
    wb(1'b0, `CETC_OFS_STATUS, 0);
    chk("held and full", 32'h048, {20'h0, rdat[15:8], rdat[3:0]});
    n0 = nfr;
    stall <= 1'b0;
    repeat (4000) if (nfr < n0 + 4) @(posedge clk_i);
    chk("burst delivered", n0 + 4, nfr);
    $display("test burst done");
    wb(1'b1, `CETC_OFS_PERIOD, 200);
    wb(1'b1, `CETC_OFS_CTRL, 32'h82);
    n0 = n_rd;
    shot(4);
    repeat (300) @(posedge clk_i);
    shot(4);
    shot(4);
    chk("rate limited", n0 + 2, n_rd);
    $display("test rate limit done");
    temp <= 12'hfff;
    n0 = ntog;
    repeat (60) @(posedge clk_i);
    chk_rng("lamp toggles", 5, 16, ntog - n0);
    temp <= 12'h100;
    repeat (100) @(posedge clk_i);
    chk("lamp off", 0, {31'h0, led});
    $display("test temperature done");
    complete_run();
  end
endmodule
`default_nettype wire
